// file: design/diag_status_flags.v
// diagnostic status word with serial register access
//
// Functional notes
// R1: over-temp latch set after filtered shutdown temperature
// R2: active mode: latch holds converters off; conditional clear
// R3: fallback: latch auto-cleared each restart period unless high warning is set
// R4: high warning real-time, clears below low threshold
// R5: low warning real-time with hysteresis clear
// R6: logic supply fail flag forces fallback
// R7: watchdog progress reports elapsed period quarter
// R8: watchdog fault read-and-clear, forces fallback
// R9: input undervoltage unless regulator from output
// R10: regulator-from-output flag with hysteresis
// R11: output-not-good, suppressed by converter disable
// R12: overvoltage flag with set and reset filters
// R13: overvoltage set blocked by disable or fault
// R14: bit zero carries odd parity over word
// R15: host toggles watchdog kick each period
// R16: latched flag clears only after acknowledged command or fallback auto-restart
// R17: status sampled once per read frame
`timescale 1ns/10ps
`include "diag_status_consts.vh"
module diag_status_flags #(
  parameter OVT_CYCLES     = (`T_OVT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter OVP_CYCLES     = (`T_OVP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter OVP_RST_CYCLES = (`T_OVP_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter AR_CYCLES      = (`T_AUTORESTART_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter WD_CYCLES      = (`T_WDOG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire       clk_in,
  input  wire       reset_n_in,
  input  wire       sck_in,
  input  wire       cs_n_in,
  input  wire       sdi_in,
  input  wire       temp_ge_shutdown_in,
  input  wire       temp_ge_warn_high_in,
  input  wire       temp_ge_warn_low_in,
  input  wire       temp_ge_warn_low_hys_in,
  input  wire       logic_supply_uv_in,
  input  wire       input_le_uv_in,
  input  wire       input_above_uv_hys_in,
  input  wire       input_le_lv_in,
  input  wire       input_above_lv_hys_in,
  input  wire       output_ge_15v_in,
  input  wire       output_below_target_in,
  input  wire       fb_above_ov_on_in,
  input  wire       fb_below_ov_off_in,
  input  wire       output_pin_fault_in,
  input  wire [1:0] converter_disable_in,
  output reg        sdo_out,
  output reg        sdo_oe_out,
  output reg  [1:0] conv_enable_out,
  output reg        fallback_out
);
  // ==========================================================
  // input synchronisation
  wire [16:0] sync_bus;
  sync_2ff #(
    .WIDTH (17)
  ) u_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({sck_in, ~cs_n_in, sdi_in, temp_ge_shutdown_in, temp_ge_warn_high_in,
                  temp_ge_warn_low_in, temp_ge_warn_low_hys_in, logic_supply_uv_in,
                  input_le_uv_in, input_above_uv_hys_in, input_le_lv_in,
                  input_above_lv_hys_in, output_ge_15v_in, output_below_target_in,
                  fb_above_ov_on_in, fb_below_ov_off_in, output_pin_fault_in}),
    .sync_out   (sync_bus)
  );

  wire s_sck        = sync_bus[16];
  // select is synchronised active high, so the cleared stages read as idle
  wire s_cs_n       = ~sync_bus[15];
  wire s_sdi        = sync_bus[14];
  wire s_tsd        = sync_bus[13];
  wire s_tw_high    = sync_bus[12];
  wire s_tw_low     = sync_bus[11];
  wire s_tw_low_hys = sync_bus[10];
  wire s_logic_uv   = sync_bus[9];
  wire s_in_uv      = sync_bus[8];
  wire s_in_uv_hys  = sync_bus[7];
  wire s_in_lv      = sync_bus[6];
  wire s_in_lv_hys  = sync_bus[5];
  wire s_out_15v    = sync_bus[4];
  wire s_out_low    = sync_bus[3];
  wire s_fb_on      = sync_bus[2];
  wire s_fb_off     = sync_bus[1];
  wire s_pin_fault  = sync_bus[0];
  wire any_disable  = |converter_disable_in;

  // ==========================================================
  // status flags
  reg        over_temp_latch;
  reg        thermal_warn_high;
  reg        thermal_warn_low;
  reg        logic_supply_fail;
  reg        wdog_fault;
  reg        input_undervoltage;
  reg        regulator_from_output;
  reg        output_not_good;
  reg        output_overvoltage;
  reg [1:0]  wdog_progress;
  reg [31:0] ovt_cnt;
  reg [31:0] ovp_cnt;
  reg [31:0] ovp_rst_cnt;
  reg [31:0] ar_cnt;
  reg [31:0] wd_cnt;

  // ==========================================================
  // serial frame state
  reg        sck_d;
  reg        cs_d;
  reg [5:0]  bit_cnt;
  reg [31:0] rx_shift;
  reg [23:0] tx_shift;
  reg [23:0] snap_word;
  reg        kick_prev;

  wire       sck_rise  = s_sck & ~sck_d;
  wire       sck_fall  = ~s_sck & sck_d;
  wire       frame_end = s_cs_n & ~cs_d;
  wire [7:0] head      = {rx_shift[6:0], s_sdi};
  // R14: odd parity check on frame
  wire       frame_ok  = frame_end && (bit_cnt == `FRAME_BITS) && (^rx_shift);
  // R16: clear only after acknowledged command
  wire       rc_ack    = frame_ok && (rx_shift[31:30] == `OP_READ_CLEAR) &&
                         (rx_shift[29:24] == `ADDR_STATUS_ONE);
  wire       kick_wr   = frame_ok && (rx_shift[31:30] == `OP_WRITE) &&
                         (rx_shift[29:24] == `ADDR_CTRL_FOUR);
  // R15: toggled kick refreshes watchdog
  wire       wd_refresh = kick_wr && (rx_shift[`BIT_KICK] != kick_prev);
  // R17: clear only what was reported
  wire       clr_ovt   = rc_ack & snap_word[`BIT_OVER_TEMP];
  wire       clr_wdf   = rc_ack & snap_word[`BIT_WDOG_FAULT];
  // R6: supply fail enters fallback
  // R8: watchdog fault enters fallback
  wire       fallback  = logic_supply_fail | wdog_fault;

  // ==========================================================
  // assembled status word
  wire [23:1] word_body = {3'h0, over_temp_latch, thermal_warn_high, thermal_warn_low,
                           logic_supply_fail, wdog_progress, wdog_fault,
                           input_undervoltage, 1'b0, regulator_from_output, 2'h0,
                           output_not_good, output_overvoltage, 6'h00};
  // R14: odd parity generation
  wire [23:0] status_word = {word_body, ~(^word_body)};

  // ==========================================================
  // filter and watchdog events
  wire ovt_set = s_tsd && (ovt_cnt == OVT_CYCLES);
  wire ovp_set = s_fb_on && (ovp_cnt == OVP_CYCLES);
  wire ovp_rst = s_fb_off && (ovp_rst_cnt == OVP_RST_CYCLES);
  wire ar_tick = (ar_cnt == AR_CYCLES - 1);
  wire wd_exp  = (wd_cnt == WD_CYCLES - 1);

  reg next_ovt;
  reg next_wdf;
  reg next_ovp;
  always @* begin
    next_ovt = over_temp_latch;
    // R2: clear only below high warning
    if (clr_ovt && !s_tw_high) begin
      next_ovt = 1'b0;
    end
    // R3: auto restart in fallback
    if (fallback && over_temp_latch && ar_tick) begin
      next_ovt = s_tw_high;
    end
    // R1: filtered shutdown sets latch
    if (ovt_set) begin
      next_ovt = 1'b1;
    end
    next_wdf = wdog_fault;
    if (clr_wdf) begin
      next_wdf = 1'b0;
    end
    // R8: expiry in active mode sets fault
    if (wd_exp && !fallback) begin
      next_wdf = 1'b1;
    end
    next_ovp = output_overvoltage;
    // R12: reset filter clears flag
    if (ovp_rst) begin
      next_ovp = 1'b0;
    end
    // R13: set blocked by disable or pin fault
    if (ovp_set && !any_disable && !s_pin_fault) begin
      next_ovp = 1'b1;
    end
  end

  // ==========================================================
  // flag registers
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      over_temp_latch       <= 1'b0;
      thermal_warn_high     <= 1'b0;
      thermal_warn_low      <= 1'b0;
      logic_supply_fail     <= 1'b0;
      wdog_fault            <= 1'b0;
      input_undervoltage    <= 1'b0;
      regulator_from_output <= 1'b0;
      output_not_good       <= 1'b0;
      output_overvoltage    <= 1'b0;
      wdog_progress         <= 2'h0;
      ovt_cnt               <= 32'h0;
      ovp_cnt               <= 32'h0;
      ovp_rst_cnt           <= 32'h0;
      ar_cnt                <= 32'h0;
      wd_cnt                <= 32'h0;
      conv_enable_out       <= 2'h0;
      fallback_out          <= 1'b0;
    end else begin
      over_temp_latch    <= next_ovt;
      wdog_fault         <= next_wdf;
      output_overvoltage <= next_ovp;
      // R1: shutdown filter counter
      ovt_cnt <= !s_tsd ? 32'h0 : (ovt_cnt == OVT_CYCLES) ? ovt_cnt : ovt_cnt + 32'h1;
      // R12: overvoltage set and reset filters
      ovp_cnt <= !s_fb_on ? 32'h0 : (ovp_cnt == OVP_CYCLES) ? ovp_cnt : ovp_cnt + 32'h1;
      ovp_rst_cnt <= !s_fb_off ? 32'h0 :
                     (ovp_rst_cnt == OVP_RST_CYCLES) ? ovp_rst_cnt : ovp_rst_cnt + 32'h1;
      // R3: restart timer runs while latched in fallback
      if (!(fallback && over_temp_latch) || ar_tick) begin
        ar_cnt <= 32'h0;
      end else begin
        ar_cnt <= ar_cnt + 32'h1;
      end
      // R4: high warning with clear below low threshold
      if (s_tw_high) begin
        thermal_warn_high <= 1'b1;
      end else if (!s_tw_low) begin
        thermal_warn_high <= 1'b0;
      end
      // R5: low warning with hysteresis
      if (s_tw_low) begin
        thermal_warn_low <= 1'b1;
      end else if (!s_tw_low_hys) begin
        thermal_warn_low <= 1'b0;
      end
      // R6: logic supply real-time flag
      logic_supply_fail <= s_logic_uv;
      // R10: regulator source with hysteresis
      if (s_in_lv && s_out_15v) begin
        regulator_from_output <= 1'b1;
      end else if (s_in_lv_hys || !s_out_15v) begin
        regulator_from_output <= 1'b0;
      end
      // R9: undervoltage masked by output supply
      if (regulator_from_output || s_in_uv_hys) begin
        input_undervoltage <= 1'b0;
      end else if (s_in_uv) begin
        input_undervoltage <= 1'b1;
      end
      // R11: not-good suppressed by disable
      output_not_good <= s_out_low & ~any_disable;
      // watchdog held in fallback, refreshed by a kick toggle
      if (fallback || wd_refresh || wd_exp) begin
        wd_cnt <= 32'h0;
      end else begin
        wd_cnt <= wd_cnt + 32'h1;
      end
      // R7: quarter of period elapsed
      if (wd_cnt < WD_CYCLES / 4) begin
        wdog_progress <= 2'h0;
      end else if (wd_cnt < WD_CYCLES / 2) begin
        wdog_progress <= 2'h1;
      end else if (wd_cnt < (WD_CYCLES / 4) * 3) begin
        wdog_progress <= 2'h2;
      end else begin
        wdog_progress <= 2'h3;
      end
      // R2: latch holds both converters off
      conv_enable_out <= ~converter_disable_in & {2{~over_temp_latch & ~s_pin_fault}};
      fallback_out    <= fallback;
    end
  end

  // ==========================================================
  // serial shift logic, mode 0, msb first
  // sck is sampled, so it must stay well below a quarter of clk_in
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sck_d      <= 1'b0;
      cs_d       <= 1'b1;
      bit_cnt    <= 6'h00;
      rx_shift   <= 32'h0;
      tx_shift   <= 24'h0;
      snap_word  <= `STATUS_RESET;
      kick_prev  <= 1'b0;
      sdo_out    <= 1'b0;
      sdo_oe_out <= 1'b0;
    end else begin
      sck_d <= s_sck;
      cs_d  <= s_cs_n;
      if (s_cs_n) begin
        bit_cnt    <= 6'h00;
        sdo_oe_out <= 1'b0;
        sdo_out    <= 1'b0;
      end else begin
        sdo_oe_out <= 1'b1;
        if (sck_rise) begin
          rx_shift <= {rx_shift[30:0], s_sdi};
          if (bit_cnt != 6'h3f) begin
            bit_cnt <= bit_cnt + 6'h01;
          end
          // R17: one snapshot per frame after the header
          if (bit_cnt == `HEAD_BITS - 6'h01) begin
            snap_word <= status_word;
            tx_shift  <= (head[5:0] == `ADDR_STATUS_ONE) ? status_word : `UNMAPPED_WORD;
          end
        end else if (sck_fall && bit_cnt >= `HEAD_BITS && bit_cnt < `FRAME_BITS) begin
          sdo_out  <= tx_shift[23];
          tx_shift <= {tx_shift[22:0], 1'b0};
        end
      end
      if (kick_wr) begin
        kick_prev <= rx_shift[`BIT_KICK];
      end
    end
  end
endmodule

// file: design/diag_status_consts.vh
// constants for the diagnostic status flag block
`ifndef DIAG_STATUS_CONSTS_VH
`define DIAG_STATUS_CONSTS_VH

// ==========================================================
// clock and timing
`define CLK_PERIOD_NS      5
`define T_OVT_NS           50000
`define T_OVP_NS           10000
`define T_OVP_RST_NS       10000
`define T_AUTORESTART_NS   10000000
`define T_WDOG_NS          50000000

// ==========================================================
// serial frame layout
`define FRAME_BITS         6'h20
`define HEAD_BITS          6'h08
`define OP_WRITE           2'h0
`define OP_READ            2'h1
`define OP_READ_CLEAR      2'h2
`define ADDR_CTRL_FOUR     6'h04
`define ADDR_STATUS_ONE    6'h06

// ==========================================================
// status word fields
`define STATUS_RESET       24'h000001
`define UNMAPPED_WORD      24'h000001
`define BIT_OVER_TEMP      20
`define BIT_WARN_HIGH      19
`define BIT_WARN_LOW       18
`define BIT_LOGIC_FAIL     17
`define BIT_WDOG_PROG_HI   16
`define BIT_WDOG_PROG_LO   15
`define BIT_WDOG_FAULT     14
`define BIT_INPUT_UV       13
`define BIT_REG_FROM_OUT   11
`define BIT_NOT_GOOD       8
`define BIT_OVERVOLT       7
`define BIT_KICK           23

`endif

// file: design/sync_2ff.v
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/10ps
module sync_2ff #(
  parameter WIDTH = 1
) (
  input  wire             clk_in,
  input  wire             reset_n_in,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;

  // ==========================================================
  // first stage feeds only the second
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// file: tb/diag_status_flags_monitor.sv
// port checker for the diagnostic status flag block
`timescale 1ns/10ps
module diag_status_flags_monitor #(
  parameter OVT_CYCLES = 8
) (
  input wire       clk_in,
  input wire       reset_n_in,
  input wire       cs_n_in,
  input wire       temp_ge_shutdown_in,
  input wire       logic_supply_uv_in,
  input wire       output_pin_fault_in,
  input wire [1:0] converter_disable_in,
  input wire       sdo_oe_out,
  input wire [1:0] conv_enable_out,
  input wire       fallback_out
);
  reg [15:0] hot;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // ========
  // shutdown dwell, saturating so a long soak never wraps
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in || !temp_ge_shutdown_in)
      hot <= 16'h0;
    else if (hot != 16'hffff)
      hot <= hot + 16'h1;
  end
  // ========
  // counts allow for two sync stages plus flag and output registers
  property p_fb; logic_supply_uv_in [*6] |-> fallback_out; endproperty
  a_fb: assert property (p_fb) else $error("fallback missing");
  property p_fb_fall; $fell(fallback_out) |-> !$past(logic_supply_uv_in, 4); endproperty
  a_fb_fall: assert property (p_fb_fall) else $error("fallback left early");
  property p_ovt; hot > OVT_CYCLES + 7 && !fallback_out |-> conv_enable_out == 2'h0; endproperty
  a_ovt: assert property (p_ovt) else $error("converter on while hot");
  property p_dis0; converter_disable_in[0] |=> !conv_enable_out[0]; endproperty
  a_dis0: assert property (p_dis0) else $error("converter 0 on");
  property p_dis1; converter_disable_in[1] |=> !conv_enable_out[1]; endproperty
  a_dis1: assert property (p_dis1) else $error("converter 1 on");
  property p_pin; output_pin_fault_in [*4] |-> conv_enable_out == 2'h0; endproperty
  a_pin: assert property (p_pin) else $error("converter on with pin fault");
  property p_oe_on; !cs_n_in [*4] |-> sdo_oe_out; endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not enabled");
  property p_oe_off; cs_n_in [*4] |-> !sdo_oe_out; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output enabled idle");
endmodule
bind diag_status_flags diag_status_flags_monitor #(.OVT_CYCLES(OVT_CYCLES)) mon (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n_in),
  .temp_ge_shutdown_in(temp_ge_shutdown_in), .logic_supply_uv_in(logic_supply_uv_in),
  .output_pin_fault_in(output_pin_fault_in), .converter_disable_in(converter_disable_in),
  .sdo_oe_out(sdo_oe_out), .conv_enable_out(conv_enable_out), .fallback_out(fallback_out));

// file: tb/host_model.sv
// host side serial master for register frames
`timescale 1ns/10ps
`include "diag_status_consts.vh"
module host_model (
  input  wire clk_in,
  input  wire sdo_in,
  output reg  sck_out,
  output reg  cs_n_out,
  output reg  sdi_out
);
  reg kick_bit;
  initial {sck_out, cs_n_out, sdi_out, kick_bit} = 4'h4;
  task clks(input integer n);
    begin
      repeat (n) @(posedge clk_in);
      #1;
    end
  endtask
  // ========
  // six clocks a half period leaves margin for the device synchronisers
  // odd parity over the frame
  task frame(input [1:0] op, input [5:0] addr, input [23:0] dat, input bad,
             output [23:0] rd);
    reg [31:0] f;
    integer    i;
    begin
      f = {op, addr, dat[23:1], 1'b0};
      f[0] = ~(^f) ^ bad;
      rd = 24'h0;
      cs_n_out = 1'b0;
      clks(6);
      for (i = 31; i >= 0; i = i - 1) begin
        {sdi_out, sck_out} = {f[i], 1'b0};
        clks(6);
        if (i < 24)
          rd = {rd[22:0], sdo_in};
        sck_out = 1'b1;
        clks(6);
      end
      sck_out = 1'b0;
      clks(6);
      cs_n_out = 1'b1;
      // released line flips so a stale level never passes for data
      sdi_out = ~sdi_out;
      clks(8);
    end
  endtask
  task kick;
    reg [23:0] nul;
    begin
      kick_bit = ~kick_bit;
      frame(`OP_WRITE, `ADDR_CTRL_FOUR, {kick_bit, 23'h0}, 1'b0, nul);
    end
  endtask
endmodule

// file: tb/tb_diag_status_flags.sv
// self-checking bench for the diagnostic status flag block
`timescale 1ns/10ps
`include "diag_status_consts.vh"
module tb_diag_status_flags;
  reg         clk_in, reset_n_in, t_sd, t_hi, t_lo, t_lh, vdd_uv, in_uv, in_uvh;
  reg         in_lv, in_lvh, o15, o_low, fb_on, fb_off, pin_f;
  reg  [1:0]  dis;
  wire        sck, cs_n, sdi, sdo, fb;
  wire [1:0]  conv;
  integer     errors, cmp_count, cyc, q;
  reg  [23:0] d;
  diag_status_flags #(.OVT_CYCLES(8), .OVP_CYCLES(8), .OVP_RST_CYCLES(8), .AR_CYCLES(40),
    .WD_CYCLES(4096)) dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .sck_in(sck), .cs_n_in(cs_n), .sdi_in(sdi),
    .temp_ge_shutdown_in(t_sd), .temp_ge_warn_high_in(t_hi), .temp_ge_warn_low_in(t_lo),
    .temp_ge_warn_low_hys_in(t_lh), .logic_supply_uv_in(vdd_uv), .input_le_uv_in(in_uv),
    .input_above_uv_hys_in(in_uvh), .input_le_lv_in(in_lv), .input_above_lv_hys_in(in_lvh),
    .output_ge_15v_in(o15), .output_below_target_in(o_low), .fb_above_ov_on_in(fb_on),
    .fb_below_ov_off_in(fb_off), .output_pin_fault_in(pin_f), .converter_disable_in(dis),
    .sdo_out(sdo), .sdo_oe_out(), .conv_enable_out(conv), .fallback_out(fb));
  host_model host (.clk_in(clk_in), .sdo_in(sdo), .sck_out(sck), .cs_n_out(cs_n),
    .sdi_out(sdi));
  always #2.5 clk_in = ~clk_in;
  // ========
  // run needs about thirty-four thousand cycles
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      errors = errors + 1;
      end_of_test;
    end
  end
  function [23:0] w(input [23:0] f);
    w = {f[23:1], ~(^f[23:1])};
  endfunction
  task cy(input integer n);
    begin
      repeat (n) @(posedge clk_in);
      #1;
    end
  endtask
  task chk(input [63:0] nm, input [23:0] e, input [23:0] s);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // kick first so the progress field stays at zero
  task rd(input [1:0] op, input [23:0] e);
    begin
      host.kick;
      host.frame(op, `ADDR_STATUS_ONE, 24'h0, 1'b0, d);
      chk("status", w(e), d);
    end
  endtask
  task end_of_test;
    begin
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // ========
  initial begin
    clk_in = 1'b0;
    reset_n_in = 1'b0;
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    {t_sd, t_hi, t_lo, t_lh, vdd_uv, in_uv, in_lv, o15, o_low, fb_on, pin_f, dis} = 13'h0;
    {in_uvh, in_lvh, fb_off} = 3'h7;
    cy(6);
    reset_n_in = 1'b1;
    cy(4);
    rd(`OP_READ, 24'h0);
    host.frame(`OP_READ, 6'h05, 24'h0, 1'b0, d);
    chk("unmapped", `UNMAPPED_WORD, d);
    {t_lo, t_lh} = 2'h3;
    rd(`OP_READ, 24'h040000);
    t_hi = 1'b1;
    rd(`OP_READ, 24'h0c0000);
    t_hi = 1'b0;
    rd(`OP_READ, 24'h0c0000);
    t_lo = 1'b0;
    rd(`OP_READ, 24'h040000);
    t_lh = 1'b0;
    rd(`OP_READ, 24'h0);
    vdd_uv = 1'b1;
    rd(`OP_READ, 24'h020000);
    chk("fallback", 24'h1, {23'h0, fb});
    vdd_uv = 1'b0;
    {in_uv, in_uvh} = 2'h2;
    rd(`OP_READ, 24'h002000);
    {in_lv, in_lvh, o15} = 3'h5;
    rd(`OP_READ, 24'h000800);
    o15 = 1'b0;
    rd(`OP_READ, 24'h002000);
    {in_uv, in_uvh, in_lv, in_lvh} = 4'h5;
    o_low = 1'b1;
    rd(`OP_READ, 24'h000100);
    dis = 2'h1;
    rd(`OP_READ, 24'h0);
    {dis, o_low, fb_on, fb_off} = 5'h2;
    cy(20);
    rd(`OP_READ, 24'h000080);
    {dis, fb_on, fb_off} = 4'h9;
    cy(20);
    rd(`OP_READ, 24'h0);
    {dis, fb_on, fb_off} = 4'ha;
    cy(20);
    rd(`OP_READ, 24'h0);
    // pin fault raised before disable drops, so the set block never lapses
    pin_f = 1'b1;
    cy(4);
    dis = 2'h0;
    cy(20);
    chk("conv", 24'h0, {22'h0, conv});
    rd(`OP_READ, 24'h0);
    {pin_f, dis, fb_on, fb_off} = 5'h1;
    {t_sd, t_hi, t_lo, t_lh} = 4'hf;
    cy(30);
    chk("conv", 24'h0, {22'h0, conv});
    rd(`OP_READ_CLEAR, 24'h1c0000);
    {t_sd, t_hi} = 2'h0;
    rd(`OP_READ, 24'h1c0000);
    host.frame(`OP_READ_CLEAR, `ADDR_STATUS_ONE, 24'h0, 1'b1, d);
    rd(`OP_READ_CLEAR, 24'h1c0000);
    rd(`OP_READ, 24'h0c0000);
    chk("conv", 24'h3, {22'h0, conv});
    {t_lo, t_lh} = 2'h0;
    {vdd_uv, t_sd, t_hi} = 3'h7;
    cy(30);
    t_sd = 1'b0;
    cy(100);
    chk("conv", 24'h0, {22'h0, conv});
    t_hi = 1'b0;
    cy(100);
    chk("conv", 24'h3, {22'h0, conv});
    vdd_uv = 1'b0;
    cy(8);
    for (q = 0; q < 4; q = q + 1) begin
      host.kick;
      cy(q * 1024 + 400);
      host.frame(`OP_READ, `ADDR_STATUS_ONE, 24'h0, 1'b0, d);
      chk("progress", w({7'h0, q[1:0], 15'h0}), d);
    end
    cy(4096);
    chk("fallback", 24'h1, {23'h0, fb});
    rd(`OP_READ_CLEAR, 24'h004000);
    cy(8);
    chk("fallback", 24'h0, {23'h0, fb});
    rd(`OP_READ, 24'h0);
    end_of_test;
  end
endmodule
